// ==== irp_pkg.sv ====
// Purpose: Constants for the input reference profiler.
// Assumes: APB registers, 8-bit duty command, 25 MHz control clock.
// Notes: Reference fractions are 8 bits, full scale means 255.
//
// Overview of operation
// - Sleep device stops motor on zero input.
// - Standby device runs low off level on zero.
// - Profile 01b selects linear breakpoint profile.
// - Below low off point output low off level.
// - Linear: hold low level, ramp to A.
// - Linear: interpolate A..E, ramp to high hold.
// - High hold until high off, hysteresis band.
// - Profile 10b selects staircase profile.
// - Staircase steps at low hold, A..E.
// - Staircase applies step hysteresis at every step.
// - Profile 11b reverses direction past breakpoint C.
// - Forward-reverse ignores direction pin and bit.
// - Forward-reverse: ramp to A, hold, off above B.
// - Above D reverse at level D, ramp, hold.
// - Above high off point use high off level.
// - Forward-reverse hysteresis only at B and D.
// - Mixed reference only in linear or staircase.
// - Mixed 01b: closed loop below C, voltage above.
// - Mixed 10b: voltage below C, closed loop above.
// - Bypass minimum reference at least low hold level.
// - Bypass target full scale at 100% duty.
// - Zero full-scale speed forces target zero, stop.
// - Profile 00b bypasses profiler, direct transfer.
// - Output is 8-bit fraction over 255.
// - Bypass voltage mode clamps below minimum duty.
package irp_pkg;
    localparam int W_DUTY = 8;
    localparam int W_FS = 16;
    localparam int W_ADDR = 8;
    localparam int W_DATA = 32;
    localparam logic [7:0] FULL_SCALE = 8'hFF;
    localparam logic [1:0] PROF_NONE = 2'h0;
    localparam logic [1:0] PROF_LIN = 2'h1;
    localparam logic [1:0] PROF_STAIR = 2'h2;
    localparam logic [1:0] PROF_FR = 2'h3;
    localparam logic [1:0] MIX_OFF = 2'h0;
    localparam logic [1:0] MIX_LOOP_LOW = 2'h1;
    localparam logic [1:0] MIX_VOLT_LOW = 2'h2;
    localparam logic [1:0] KIND_SPEED = 2'h0;
    localparam logic [1:0] KIND_VOLT = 2'h3;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_LOW = 8'h04;
    localparam logic [7:0] OFS_HIGH = 8'h08;
    localparam logic [7:0] OFS_LVL = 8'h0C;
    localparam logic [7:0] OFS_BP = 8'h10;
    localparam logic [7:0] OFS_BPE = 8'h14;
    localparam logic [7:0] OFS_REFS = 8'h18;
    localparam logic [7:0] OFS_STAT = 8'h1C;
    localparam int CTRL_PROF = 0;
    localparam int CTRL_MIX = 2;
    localparam int CTRL_KIND = 4;
    localparam int CTRL_STBY = 6;
    localparam int CTRL_DIR = 7;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam int N_THR = 8;
    localparam int THR_B = 6;
    localparam int THR_D = 7;
endpackage

// ==== irp_profiler.sv ====
// Purpose: Maps the duty command to a motor control reference.
// Assumes: Duty command comes from logic on the same clock.
// Notes: The APB slave answers with no wait states while enabled.
`timescale 1ns/1ns
module irp_profiler (
    input wire logic I_CLK, // Control clock, 25 MHz.
    input wire logic I_RST_N, // Synchronous reset, active low.
    input wire logic I_CE, // Clock enable, freezes all state.
    input wire logic I_PSEL, // APB select.
    input wire logic I_PENABLE, // APB enable.
    input wire logic I_PWRITE, // APB write.
    input wire logic [irp_pkg::W_ADDR-1:0] I_PADDR, // APB address.
    input wire logic [irp_pkg::W_DATA-1:0] I_PWDATA, // APB write data.
    output logic [irp_pkg::W_DATA-1:0] O_PRDATA, // APB read data.
    output logic O_PREADY, // APB ready.
    output logic O_PSLVERR, // APB error, unmapped address.
    input wire logic [irp_pkg::W_DUTY-1:0] I_DUTY, // Duty command.
    input wire logic I_DIR_PIN, // External direction pin.
    output logic [7:0] O_REF, // Reference fraction over 255.
    output logic [irp_pkg::W_FS-1:0] O_TARGET, // Scaled target.
    output logic O_DIR_REV, // Reverse direction command.
    output logic O_STOP, // Motor stop request.
    output logic O_VOLT_MODE // Voltage reference control active.
);
    import irp_pkg::*;

    ////////////////////////////////////////////////////////////////////
    logic [31:0] ctrl, low_w, high_w, lvl_w, bp_w, bpe_w, refs_w;
    logic dir_s1, dir_s2;
    logic [N_THR-1:0] thr_st;
    logic low_off_st, high_off_st;

    wire [1:0] prof = ctrl[CTRL_PROF+:2];
    wire [1:0] mix = ctrl[CTRL_MIX+:2];
    wire [1:0] kind = ctrl[CTRL_KIND+:2];
    wire standby_dev = ctrl[CTRL_STBY];
    wire dir_bit = ctrl[CTRL_DIR];
    wire [7:0] low_off_level = low_w[7:0];
    wire [7:0] low_off_point = low_w[15:8];
    wire [7:0] low_on_point = low_w[23:16];
    wire [7:0] low_hold_point = low_w[31:24];
    wire [7:0] high_off_level = high_w[7:0];
    wire [7:0] high_off_point = high_w[15:8];
    wire [7:0] high_on_point = high_w[23:16];
    wire [7:0] high_hold_point = high_w[31:24];
    wire [7:0] low_hold_level = lvl_w[7:0];
    wire [7:0] high_hold_level = lvl_w[15:8];
    wire [7:0] step_hysteresis = lvl_w[23:16];
    wire [7:0] min_duty = lvl_w[31:24];
    wire [W_FS-1:0] full_scale = bpe_w[31:16];
    wire [7:0] duty = I_DUTY;

    // Points 0..6: low hold point, breakpoints A..E, high hold point.
    wire [7:0] pt [0:6];
    wire [7:0] lv [0:6];
    assign pt[0] = low_hold_point;
    assign pt[1] = bp_w[7:0];
    assign pt[2] = bp_w[15:8];
    assign pt[3] = bp_w[23:16];
    assign pt[4] = bp_w[31:24];
    assign pt[5] = bpe_w[7:0];
    assign pt[6] = high_hold_point;
    assign lv[0] = low_hold_level;
    assign lv[1] = refs_w[7:0];
    assign lv[2] = refs_w[15:8];
    assign lv[3] = refs_w[23:16];
    assign lv[4] = refs_w[31:24];
    assign lv[5] = bpe_w[15:8];
    assign lv[6] = high_hold_level;

    ////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] interp(input logic [7:0] d,
            input logic [7:0] x0, input logic [7:0] x1,
            input logic [7:0] y0, input logic [7:0] y1);
        logic signed [9:0] dy;
        logic signed [19:0] prod;
        logic signed [19:0] q;
        dy = $signed({2'h0, y1}) - $signed({2'h0, y0});
        prod = dy * $signed({2'h0, 8'(d - x0)});
        q = (x1 == x0) ? 20'(dy)
            : prod / $signed({12'h000, 8'(x1 - x0)});
        interp = 8'(y0 + q[7:0]);
    endfunction

    function automatic logic [2:0] count_steps(input logic [5:0] s);
        logic [2:0] n;
        n = 3'h0;
        for (int i = 0; i < 6; i++) begin
            n = n + {2'h0, s[i]};
        end
        count_steps = n;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Interpolated value of each linear segment between points i, i+1.
    wire [7:0] seg [0:5];
    wire [7:0] thr [0:N_THR-1];
    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : g_seg
            assign seg[g] = interp(duty, pt[g], pt[g+1], lv[g], lv[g+1]);
            assign thr[g] = pt[g];
        end
    endgenerate
    assign thr[THR_B] = bp_w[15:8];
    assign thr[THR_D] = bp_w[31:24];

    // Each step edge is a held comparator: up on reaching the point,
    // down only once the command drops a full hysteresis width below.
    generate
        for (g = 0; g < N_THR; g++) begin : g_thr
            wire up = duty >= thr[g];
            wire dn = ({1'b0, duty} + {1'b0, step_hysteresis})
                < {1'b0, thr[g]};
            always_ff @(posedge I_CLK) begin
                if (!I_RST_N) begin
                    thr_st[g] <= 1'b0;
                end else if (I_CE) begin
                    thr_st[g] <= up | (thr_st[g] & ~dn);
                end
            end
        end
    endgenerate

    // Off bands: the held state decides between the two thresholds.
    wire next_low_off = (duty < low_off_point)
        | (low_off_st & ~(duty > low_on_point));
    wire next_high_off = (duty > high_off_point)
        | (high_off_st & ~(duty < high_on_point));

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            low_off_st <= 1'b0;
            high_off_st <= 1'b0;
        end else if (I_CE) begin
            low_off_st <= next_low_off;
            high_off_st <= next_high_off;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Linear profile value, segment chosen by where the command sits.
    logic [7:0] lin_val;
    always_comb begin
        lin_val = high_hold_level;
        for (int i = 5; i >= 0; i--) begin
            if (duty <= pt[i+1]) begin
                lin_val = seg[i];
            end
        end
        if (duty <= pt[0]) begin
            lin_val = low_hold_level;
        end
    end

    wire [2:0] stair_idx = count_steps(thr_st[5:0]);
    wire [7:0] stair_val = lv[stair_idx];

    // Forward-reverse: the B and D edges carry the step hysteresis.
    wire fr_off = thr_st[THR_B] & ~thr_st[THR_D];
    // The reverse ramp leaves from level D, which holds up to E, so the
    // reference has no jump at breakpoint E.
    wire [7:0] fr_ramp = interp(duty, pt[5], pt[6], lv[4], lv[6]);
    logic [7:0] fr_val;
    always_comb begin
        if (duty <= pt[0]) begin
            fr_val = low_hold_level;
        end else if (duty <= pt[1]) begin
            fr_val = seg[0];
        end else if (!thr_st[THR_D]) begin
            fr_val = lv[1];
        end else if (duty <= pt[5]) begin
            fr_val = lv[4];
        end else if (duty <= pt[6]) begin
            fr_val = fr_ramp;
        end else begin
            fr_val = high_hold_level;
        end
    end

    // Bypass: straight duty, floored at the larger of the two minima.
    wire [7:0] floor_ref = (min_duty < low_hold_level)
        ? low_hold_level : min_duty;
    wire below_min = duty < min_duty;
    wire [7:0] byp_val = (kind == KIND_VOLT && below_min) ? 8'h00
        : (duty < floor_ref) ? floor_ref : duty;

    ////////////////////////////////////////////////////////////////////
    logic [7:0] next_ref;
    logic next_stop;
    wire zero_in = duty == 8'h00;
    wire fs_zero = kind == KIND_SPEED && full_scale == 16'h0000;

    always_comb begin
        next_stop = 1'b0;
        case (prof)
            PROF_LIN: next_ref = lin_val;
            PROF_STAIR: next_ref = stair_val;
            PROF_FR: next_ref = fr_val;
            default: next_ref = byp_val;
        endcase
        if (prof == PROF_FR && fr_off && duty <= pt[5]) begin
            next_ref = 8'h00;
            next_stop = 1'b1;
        end
        if (prof != PROF_NONE && high_off_st) begin
            next_ref = high_off_level;
        end
        if (prof != PROF_NONE && low_off_st) begin
            next_ref = low_off_level;
        end
        if (zero_in) begin
            next_ref = standby_dev ? low_off_level : 8'h00;
            next_stop = ~standby_dev;
        end
        if (fs_zero) begin
            next_stop = 1'b1;
        end
    end

    // Direction in forward-reverse follows breakpoint C alone.
    wire next_dir = (prof == PROF_FR) ? (duty > pt[3])
        : (dir_s2 ^ dir_bit);

    // Mixed reference only where a breakpoint profile is active.
    wire mix_ok = prof == PROF_LIN || prof == PROF_STAIR;
    wire past_c = duty >= pt[3];
    wire next_volt = (mix_ok && mix == MIX_LOOP_LOW) ? past_c
        : (mix_ok && mix == MIX_VOLT_LOW) ? ~past_c
        : (kind == KIND_VOLT);

    // Target scales the fraction by the full-scale value over 255.
    wire [23:0] prod_fs = {16'h0000, O_REF} * {8'h00, full_scale};
    wire [W_FS-1:0] next_target = fs_zero ? 16'h0000
        : 16'(prod_fs / {16'h0000, FULL_SCALE});

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            dir_s1 <= 1'b0;
            dir_s2 <= 1'b0;
            O_REF <= 8'h00;
            O_TARGET <= 16'h0000;
            O_DIR_REV <= 1'b0;
            O_STOP <= 1'b1;
            O_VOLT_MODE <= 1'b0;
        end else if (I_CE) begin
            dir_s1 <= I_DIR_PIN;
            dir_s2 <= dir_s1;
            O_REF <= next_ref;
            O_TARGET <= next_target;
            O_DIR_REV <= next_dir;
            O_STOP <= next_stop;
            O_VOLT_MODE <= next_volt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // APB slave. Read data is latched in the setup cycle so that it
    // leaves a flip-flop; the status word is therefore one cycle old.
    wire [W_DATA-1:0] stat_w = {19'h0, high_off_st, low_off_st,
        O_VOLT_MODE, O_STOP, O_DIR_REV, O_REF};
    wire sel_ctrl = I_PADDR == OFS_CTRL;
    wire sel_low = I_PADDR == OFS_LOW;
    wire sel_high = I_PADDR == OFS_HIGH;
    wire sel_lvl = I_PADDR == OFS_LVL;
    wire sel_bp = I_PADDR == OFS_BP;
    wire sel_bpe = I_PADDR == OFS_BPE;
    wire sel_refs = I_PADDR == OFS_REFS;
    wire sel_stat = I_PADDR == OFS_STAT;
    wire mapped = sel_ctrl | sel_low | sel_high | sel_lvl | sel_bp
        | sel_bpe | sel_refs | sel_stat;
    wire wr = I_CE & I_PSEL & I_PENABLE & I_PWRITE;
    wire [W_DATA-1:0] rd_mux = sel_ctrl ? {24'h0, ctrl[7:0]}
        : sel_low ? low_w : sel_high ? high_w : sel_lvl ? lvl_w
        : sel_bp ? bp_w : sel_bpe ? bpe_w : sel_refs ? refs_w
        : sel_stat ? stat_w : 32'h0000_0000;

    assign O_PREADY = I_CE;
    assign O_PSLVERR = I_PSEL & I_PENABLE & ~mapped;

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            ctrl <= RST_WORD;
            low_w <= RST_WORD;
            high_w <= RST_WORD;
            lvl_w <= RST_WORD;
            bp_w <= RST_WORD;
            bpe_w <= RST_WORD;
            refs_w <= RST_WORD;
            O_PRDATA <= RST_WORD;
        end else if (I_CE) begin
            if (wr && sel_ctrl) ctrl <= {24'h0, I_PWDATA[7:0]};
            if (wr && sel_low) low_w <= I_PWDATA;
            if (wr && sel_high) high_w <= I_PWDATA;
            if (wr && sel_lvl) lvl_w <= I_PWDATA;
            if (wr && sel_bp) bp_w <= I_PWDATA;
            if (wr && sel_bpe) bpe_w <= I_PWDATA;
            if (wr && sel_refs) refs_w <= I_PWDATA;
            if (I_PSEL && !I_PENABLE) O_PRDATA <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);

    property p_sleep_zero;
        I_CE && zero_in && !standby_dev |=> O_STOP && O_REF == 8'h00;
    endproperty
    a_sleep_zero: assert property (p_sleep_zero)
        else $error("zero input did not stop a sleep device");

    property p_standby_zero;
        I_CE && zero_in && standby_dev && !fs_zero
            |=> !O_STOP && O_REF == $past(low_off_level);
    endproperty
    a_standby_zero: assert property (p_standby_zero)
        else $error("standby device not at low off level");

    property p_low_band;
        I_CE && duty < low_off_point ##1 I_CE && !zero_in
            && prof != PROF_NONE |=> O_REF == $past(low_off_level);
    endproperty
    a_low_band: assert property (p_low_band)
        else $error("low off band not applied");

    property p_lin_hold;
        I_CE && prof == PROF_LIN && !zero_in && !low_off_st
            && !high_off_st && duty <= low_hold_point
            |=> O_REF == $past(low_hold_level);
    endproperty
    a_lin_hold: assert property (p_lin_hold)
        else $error("linear low hold level wrong");

    property p_fr_dir;
        I_CE && prof == PROF_FR |=> O_DIR_REV == ($past(duty) > $past(pt[3]));
    endproperty
    a_fr_dir: assert property (p_fr_dir)
        else $error("forward-reverse direction wrong");

    property p_fr_pin;
        I_CE && prof == PROF_FR && duty <= pt[3] && dir_s2 |=> !O_DIR_REV;
    endproperty
    a_fr_pin: assert property (p_fr_pin)
        else $error("direction pin used in forward-reverse");

    property p_mix_fr;
        I_CE && prof == PROF_FR
            |=> O_VOLT_MODE == ($past(kind) == KIND_VOLT);
    endproperty
    a_mix_fr: assert property (p_mix_fr)
        else $error("mixed reference active outside allowed profiles");

    property p_mix_loop;
        I_CE && prof == PROF_LIN && mix == MIX_LOOP_LOW && duty >= pt[3]
            |=> O_VOLT_MODE;
    endproperty
    a_mix_loop: assert property (p_mix_loop)
        else $error("voltage mode not taken above C");

    property p_fs_zero;
        I_CE && fs_zero |=> O_STOP && O_TARGET == 16'h0000;
    endproperty
    a_fs_zero: assert property (p_fs_zero)
        else $error("zero full scale did not force stop");

    property p_byp_volt;
        I_CE && prof == PROF_NONE && kind == KIND_VOLT && below_min
            && !zero_in |=> O_REF == 8'h00;
    endproperty
    a_byp_volt: assert property (p_byp_volt)
        else $error("voltage not clamped below minimum duty");

    property p_unmapped;
        I_PSEL && I_PENABLE && !mapped |-> O_PSLVERR;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access not flagged");

    c_lin: cover property (I_CE && prof == PROF_LIN && O_REF == lv[3]);
    c_stair: cover property (I_CE && prof == PROF_STAIR && stair_idx == 3'h6);
    c_fr_rev: cover property (I_CE && prof == PROF_FR && O_DIR_REV);
    c_high_off: cover property (high_off_st ##1 !high_off_st);
endmodule

// ==== irp_speed_source.sv ====
// Purpose: Behavioural speed input decoder feeding the profiler.
// Assumes: Decoded duty and direction pin change on the control clock.
// Notes: It only registers what the bench asks for; it never glitches.
`timescale 1ns/1ns
module irp_speed_source (
    input wire logic i_clk, // Control clock.
    input wire logic i_rst_n, // Synchronous reset, active low.
    input wire logic [7:0] i_duty_req, // Wanted duty command.
    input wire logic i_pin_req, // Wanted direction pin level.
    output logic [7:0] o_duty, // Decoded duty command.
    output logic o_dir_pin // External direction pin.
);
    ////////////////////////////////////////////////////////////
    // A decoder holds a zero command until it has seen an input.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_duty <= 8'h00;
            o_dir_pin <= 1'b0;
        end else begin
            o_duty <= i_duty_req;
            o_dir_pin <= i_pin_req;
        end
    end
endmodule

// ==== test_input_reference_profiler.sv ====
// Purpose: Self-checking bench for the input reference profiler.
// Assumes: APB slave with no wait states, settings as in the package.
// Notes: Breakpoint levels equal breakpoints, so ramps are exact.
`timescale 1ns/1ns
module test_input_reference_profiler;
    import irp_pkg::*;
    `define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
        err_total++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); \
        end end
    logic clk, rst_n, psel, penable, pwrite, pin_req, rdy, err, re;
    logic [W_ADDR-1:0] paddr;
    logic [W_DATA-1:0] pwdata, rdata, rq;
    logic [7:0] duty_req, duty, ref_o;
    logic dir_pin, dir_rev, stop, volt;
    logic [W_FS-1:0] target;
    int err_total = 0;
    int n_compared = 0;
    int cycles = 0;
    irp_speed_source src (.i_clk(clk), .i_rst_n(rst_n),
        .i_duty_req(duty_req), .i_pin_req(pin_req), .o_duty(duty),
        .o_dir_pin(dir_pin));
    irp_profiler uut (.I_CLK(clk), .I_RST_N(rst_n), .I_CE(1'b1),
        .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
        .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(rdata),
        .O_PREADY(rdy), .O_PSLVERR(err), .I_DUTY(duty),
        .I_DIR_PIN(dir_pin), .O_REF(ref_o), .O_TARGET(target),
        .O_DIR_REV(dir_rev), .O_STOP(stop), .O_VOLT_MODE(volt));
    ////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (rdy !== 1'b1);
        rq = rdata;
        re = err;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [31:0] ctl(input logic [1:0] p,
        input logic [1:0] m, input logic [1:0] k, input logic s);
        return {24'h000000, 1'b0, s, k, m, p};
    endfunction
    // Full scale is a parameter; the zero full-scale case writes OFS_BPE directly instead.
    task automatic cfg(input logic [15:0] fs);
        apb(1'b1, OFS_LOW, 32'h140F0A05);
        apb(1'b1, OFS_HIGH, 32'hDCE6F010);
        apb(1'b1, OFS_LVL, 32'h1404E619);
        apb(1'b1, OFS_BP, 32'hA0785028);
        apb(1'b1, OFS_BPE, {fs, 16'hC8C8});
        apb(1'b1, OFS_REFS, 32'hA0785028);
    endtask
    // Six edges cover the source flop, band update and target lag.
    task automatic dut(input logic [7:0] x);
        duty_req <= x;
        repeat (6) @(posedge clk);
    endtask
    task automatic step(input logic [7:0] x, input logic [7:0] r);
        dut(x);
        `CHK("ref", r, ref_o)
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        duty_req = 8'h00;
        pin_req = 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        cfg(16'h1234);
        apb(1'b0, OFS_LVL, 32'h00000000);
        `CHK("lvl", 32'h1404E619, rq)
        apb(1'b1, 8'h20, 32'hFFFFFFFF);
        `CHK("wr_err", 1'b1, re)
        apb(1'b0, 8'h20, 32'h00000000);
        `CHK("rd_bad", 32'h00000000, rq)
        apb(1'b1, OFS_CTRL, ctl(PROF_NONE, MIX_OFF, KIND_SPEED, 1'b0));
        step(8'hFF, 8'hFF);
        `CHK("target", 16'h1234, target)
        step(8'h05, 8'h19);
        dut(8'h00);
        `CHK("sleep", 1'b1, stop)
        pin_req <= 1'b1;
        dut(8'h64);
        `CHK("dir", 1'b1, dir_rev)
        apb(1'b1, OFS_CTRL, ctl(PROF_NONE, MIX_OFF, KIND_VOLT, 1'b0));
        step(8'h0A, 8'h00);
        step(8'h64, 8'h64);
        `CHK("volt", 1'b1, volt)
        apb(1'b1, OFS_CTRL, ctl(PROF_NONE, MIX_OFF, KIND_SPEED, 1'b0));
        apb(1'b1, OFS_BPE, 32'h0000C8C8);
        dut(8'h64);
        `CHK("fs0_stop", 1'b1, stop)
        `CHK("fs0_tgt", 16'h0000, target)
        apb(1'b1, OFS_BPE, 32'h1234C8C8);
        apb(1'b1, OFS_CTRL, ctl(PROF_LIN, MIX_OFF, KIND_SPEED, 1'b1));
        step(8'h00, 8'h05);
        `CHK("stby", 1'b0, stop)
        step(8'h05, 8'h05);
        step(8'h0C, 8'h05);
        step(8'h12, 8'h19);
        step(8'h24, 8'h25);
        step(8'h64, 8'h64);
        step(8'hD2, 8'hD7);
        step(8'hE6, 8'hE6);
        step(8'hF5, 8'h10);
        step(8'hEB, 8'h10);
        step(8'hE1, 8'hE6);
        apb(1'b1, OFS_CTRL, ctl(PROF_LIN, MIX_LOOP_LOW, KIND_SPEED, 1'b0));
        dut(8'h64);
        `CHK("mix1_lo", 1'b0, volt)
        dut(8'h82);
        `CHK("mix1_hi", 1'b1, volt)
        apb(1'b1, OFS_CTRL, ctl(PROF_STAIR, MIX_VOLT_LOW, KIND_SPEED, 1'b0));
        dut(8'h82);
        `CHK("mix2_hi", 1'b0, volt)
        step(8'h1E, 8'h28);
        `CHK("mix2_lo", 1'b1, volt)
        apb(1'b1, OFS_CTRL, ctl(PROF_STAIR, MIX_OFF, KIND_SPEED, 1'b0));
        step(8'h64, 8'h78);
        step(8'hC8, 8'hE6);
        step(8'h4E, 8'h78);
        step(8'h4B, 8'h50);
        apb(1'b1, OFS_CTRL, ctl(PROF_FR, MIX_LOOP_LOW, KIND_SPEED, 1'b0));
        step(8'h3C, 8'h28);
        `CHK("fwd", 1'b0, dir_rev)
        dut(8'h64);
        `CHK("fr_off", 1'b1, stop)
        step(8'hAA, 8'hA0);
        `CHK("rev", 1'b1, dir_rev)
        `CHK("rev_run", 1'b0, stop)
        `CHK("fr_mix", 1'b0, volt)
        step(8'h9E, 8'hA0);
        step(8'hD2, 8'hC3);
        step(8'hF5, 8'h10);
        `CHK("rev_hi", 1'b1, dir_rev)
        stop_test();
    end
endmodule
